// ---- xfer_pkg.sv ----
package xfer_pkg;

  // ==========================================================================
  // Character and word geometry
  // ==========================================================================
  localparam int CHAR_W       = 6;
  localparam int WORD_CHARS   = 12;
  localparam int BUF_WORDS    = 10;
  localparam int BUF_CHARS    = 120;
  localparam int POS_W        = 7;
  localparam int WORD_W       = CHAR_W * WORD_CHARS;
  localparam int LOW_WORD     = 9;
  localparam int LOW_POS      = 0;
  localparam int POINTER_DIG  = 7;

  // ==========================================================================
  // Operation codes (two characters, S suffix)
  // ==========================================================================
  localparam logic [11:0] OP_BUFFER_COPY  = 12'h0_8D3;
  localparam logic [11:0] OP_LOAD_POINTER = 12'h0_C53;
  localparam logic [11:0] OP_LOAD_ROTATE  = 12'h0_C93;
  localparam logic [11:0] OP_CLEAR_TRACK  = 12'h0_CD3;

  // ==========================================================================
  // Location classes decoded upstream from U and W addresses
  // ==========================================================================
  localparam logic [2:0] LOC_INVALID   = 3'h0;
  localparam logic [2:0] LOC_DRUM_WORD = 3'h1;
  localparam logic [2:0] LOC_STORE_FLD = 3'h2;
  localparam logic [2:0] LOC_STAGING   = 3'h3;
  localparam logic [2:0] LOC_PATTERN   = 3'h4;
  localparam logic [2:0] LOC_DRUM_PAT  = 3'h5;

  // Space code and clock-independent constants
  localparam logic [5:0] SPACE_CODE    = 6'h0_0;
  localparam logic [6:0] LEN_ZERO      = 7'h0_0;
  localparam logic [6:0] LEN_ONE       = 7'h0_1;
  localparam logic [6:0] LEN_FULL      = 7'h7_8;
  localparam logic [6:0] LEN_FIELD_MAX = 7'h7_7;
  localparam logic [6:0] LEN_WORD      = 7'h0_C;

endpackage : xfer_pkg

// ---- pair_buffer.sv ----
`timescale 1ns/1ps
// ============================================================================
// Two-entry buffer: a receiver stall never drops a character
// ============================================================================
module pair_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  input  wire logic             enable_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  logic [WIDTH-1:0] slot_reg [2];
  logic [WIDTH-1:0] slot_next [2];
  logic [1:0]       count_reg;
  logic [1:0]       count_next;
  logic             valid_reg;
  logic             valid_next;
  logic             push;
  logic             pop;

  // Next state: slot 0 is always the head
  always_comb
  begin
    push         = in_valid_i && (count_reg != 2'h2);
    pop          = out_ready_i && (count_reg != 2'h0);
    slot_next[0] = slot_reg[0];
    slot_next[1] = slot_reg[1];
    count_next   = count_reg;
    if (pop)
    begin
      slot_next[0] = slot_reg[1];
    end
    if (push)
    begin
      if (count_reg == 2'h0 || (count_reg == 2'h1 && pop))
        slot_next[0] = in_data_i;
      else if (pop)
        slot_next[1] = in_data_i;
      else
        slot_next[1] = in_data_i;
    end
    count_next = 2'(count_reg + {1'b0, push} - {1'b0, pop});
    // Valid kept in its own flop so the top output leaves a register
    valid_next = (count_next != 2'h0);
  end

  // Registers
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
      count_reg   <= 2'h0;
      valid_reg   <= 1'b0;
    end
    else if (enable_i)
    begin
      slot_reg[0] <= slot_next[0];
      slot_reg[1] <= slot_next[1];
      count_reg   <= count_next;
      valid_reg   <= valid_next;
    end
  end

  assign in_ready_o  = (count_reg != 2'h2);
  assign out_valid_o = valid_reg;
  assign out_data_o  = slot_reg[0];

endmodule // pair_buffer

// ---- buffer_transfer_load_clear_unit.sv ----
`timescale 1ns/1ps
module buffer_transfer_load_clear_unit #(
  parameter int CHAR_W = xfer_pkg::CHAR_W
) (
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  input  wire logic              enable_i,
  // Instruction strobe and active instruction word sections
  input  wire logic              start_i,
  input  wire logic [11:0]       op_code_i,
  input  wire logic [17:0]       u_section_i,
  input  wire logic [17:0]       v_section_i,
  input  wire logic [17:0]       w_section_i,
  input  wire logic [5:0]        step_code_i,
  // Location classes and lengths decoded from U and W addresses
  input  wire logic [2:0]        src_class_i,
  input  wire logic [6:0]        src_len_i,
  input  wire logic [2:0]        dst_class_i,
  input  wire logic [6:0]        dst_len_i,
  // Source character stream, lowest-order first
  input  wire logic              src_valid_i,
  output logic                   src_ready_o,
  input  wire logic [CHAR_W-1:0] src_char_i,
  // Destination character stream, lowest-order first
  output logic                   dst_valid_o,
  input  wire logic              dst_ready_i,
  output logic [CHAR_W-1:0]      dst_char_o,
  // Results
  output logic [41:0]            bulk_store_pointer_o,
  output logic                   pointer_load_o,
  output logic [71:0]            rotate_holding_word_o,
  output logic                   rotate_load_o,
  output logic                   halt_o,
  output logic                   done_o,
  output logic [5:0]             step_code_o
);

  // ==========================================================================
  // Types and state
  // ==========================================================================
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_FILL  = 6'b00_0010,
    ST_SEND  = 6'b00_0100,
    ST_CLEAR = 6'b00_1000,
    ST_DRAIN = 6'b01_0000,
    ST_END   = 6'b10_0000
  } seq_state_type;

  localparam int POS_W = xfer_pkg::POS_W;

  seq_state_type     state_reg, state_next;
  logic [CHAR_W-1:0] stage_reg [xfer_pkg::BUF_CHARS];
  logic [POS_W-1:0]  pos_reg, pos_next;
  logic [POS_W-1:0]  limit_reg, limit_next;
  logic              send_after_reg, send_after_next;
  logic [5:0]        step_reg, step_next;
  logic [41:0]       pointer_reg, pointer_next;
  logic [71:0]       rotate_reg, rotate_next;
  logic              pointer_load_reg, pointer_load_next;
  logic              rotate_load_reg, rotate_load_next;
  logic              halt_reg, halt_next;
  logic              done_reg, done_next;
  logic              src_ready_reg, src_ready_next;
  logic              stage_we;
  logic [POS_W-1:0]  stage_waddr;
  logic              buf_in_valid;
  logic              buf_in_ready;
  logic [CHAR_W-1:0] buf_in_data;
  logic              buf_out_valid;
  logic [CHAR_W-1:0] buf_out_data;
  logic              src_ok;
  logic              dst_ok;
  logic              src_stage;
  logic              dst_stage;

  // ==========================================================================
  // Location checks: staging addresses are matched by class only, so the
  // low-order address character never reaches this block
  // ==========================================================================
  always_comb
  begin
    src_stage = (src_class_i == xfer_pkg::LOC_STAGING);
    dst_stage = (dst_class_i == xfer_pkg::LOC_STAGING);
    case (src_class_i)
      xfer_pkg::LOC_DRUM_WORD: src_ok = (src_len_i == xfer_pkg::LEN_WORD);
      xfer_pkg::LOC_STORE_FLD: src_ok = (src_len_i >= xfer_pkg::LEN_ONE)
                                        && (src_len_i <= xfer_pkg::LEN_FULL);
      xfer_pkg::LOC_STAGING:   src_ok = 1'b1;
      default:                 src_ok = 1'b0;
    endcase
    case (dst_class_i)
      xfer_pkg::LOC_DRUM_WORD: dst_ok = (dst_len_i == xfer_pkg::LEN_WORD);
      xfer_pkg::LOC_STORE_FLD: dst_ok = (dst_len_i >= xfer_pkg::LEN_ONE)
                                        && (dst_len_i <= xfer_pkg::LEN_FULL);
      xfer_pkg::LOC_PATTERN,
      xfer_pkg::LOC_DRUM_PAT:  dst_ok = (dst_len_i == xfer_pkg::LEN_FULL);
      xfer_pkg::LOC_STAGING:   dst_ok = 1'b1;
      default:                 dst_ok = 1'b0;
    endcase
  end

  // ==========================================================================
  // Sequencer next state
  // ==========================================================================
  always_comb
  begin
    state_next        = state_reg;
    pos_next          = pos_reg;
    limit_next        = limit_reg;
    send_after_next   = send_after_reg;
    step_next         = step_reg;
    pointer_next      = pointer_reg;
    rotate_next       = rotate_reg;
    pointer_load_next = 1'b0;
    rotate_load_next  = 1'b0;
    halt_next         = halt_reg;
    done_next         = 1'b0;
    src_ready_next    = 1'b0;
    stage_we          = 1'b0;
    stage_waddr       = pos_reg;
    buf_in_valid      = 1'b0;
    buf_in_data       = stage_reg[pos_reg];
    case (state_reg)
      ST_IDLE:
      begin
        if (start_i && !halt_reg)
        begin
          step_next = step_code_i;
          pos_next  = xfer_pkg::LEN_ZERO;  // Index 0 is word 9 position S
          case (op_code_i)
            xfer_pkg::OP_BUFFER_COPY:
            begin
              // V address plays no part in the copy
              if (!src_ok || !dst_ok)
                halt_next = 1'b1;
              else if (src_stage && dst_stage)
                state_next = ST_END;
              else if (src_stage)
              begin
                limit_next = dst_len_i;  // Count set by destination
                state_next = ST_SEND;
              end
              else
              begin
                limit_next      = src_len_i;
                send_after_next = !dst_stage;
                src_ready_next  = 1'b1;
                state_next      = ST_FILL;
              end
            end
            xfer_pkg::OP_LOAD_POINTER:
            begin
              // Target is fixed, no destination decode
              pointer_next      = {u_section_i[11:0], v_section_i, w_section_i[17:6]};
              pointer_load_next = 1'b1;
              state_next        = ST_END;
            end
            xfer_pkg::OP_LOAD_ROTATE:
            begin
              rotate_next      = {u_section_i, v_section_i, w_section_i,
                                  op_code_i, step_code_i};
              rotate_load_next = 1'b1;
              state_next       = ST_END;
            end
            xfer_pkg::OP_CLEAR_TRACK:
            begin
              limit_next = xfer_pkg::LEN_FULL;  // U and V ignored
              state_next = ST_CLEAR;
            end
            default:
            begin
              state_next = ST_IDLE;
            end
          endcase
        end
      end
      ST_FILL:
      begin
        // Only source positions are written; higher ones keep old data
        src_ready_next = 1'b1;
        if (src_valid_i && src_ready_reg)
        begin
          stage_we    = 1'b1;
          stage_waddr = pos_reg;
          pos_next    = POS_W'(pos_reg + 1'b1);
          if (pos_next == limit_reg)
          begin
            src_ready_next = 1'b0;
            pos_next       = xfer_pkg::LEN_ZERO;
            limit_next     = dst_len_i;
            state_next     = send_after_reg ? ST_SEND : ST_END;
          end
        end
      end
      ST_SEND:
      begin
        // Upper destination positions take older staging data
        buf_in_valid = 1'b1;
        buf_in_data  = stage_reg[pos_reg];
        if (buf_in_ready)
        begin
          pos_next = POS_W'(pos_reg + 1'b1);
          if (pos_next == limit_reg)
            state_next = ST_DRAIN;  // Rest of staging is not sent
        end
      end
      ST_CLEAR:
      begin
        buf_in_valid = 1'b1;
        buf_in_data  = xfer_pkg::SPACE_CODE;  // Spaces made internally
        if (buf_in_ready)
        begin
          pos_next = POS_W'(pos_reg + 1'b1);
          if (pos_next == limit_reg)
            state_next = ST_DRAIN;
        end
      end
      ST_DRAIN:
      begin
        // Completion waits until the receiver has taken every character
        if (!buf_out_valid)
          state_next = ST_END;
      end
      ST_END:
      begin
        done_next  = 1'b1;  // Sub-step per S/C
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Sequencer registers
  // ==========================================================================
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg        <= ST_IDLE;
      pos_reg          <= '0;
      limit_reg        <= '0;
      send_after_reg   <= 1'b0;
      step_reg         <= '0;
      pointer_reg      <= '0;
      rotate_reg       <= '0;
      pointer_load_reg <= 1'b0;
      rotate_load_reg  <= 1'b0;
      halt_reg         <= 1'b0;
      done_reg         <= 1'b0;
      src_ready_reg    <= 1'b0;
    end
    else if (enable_i)
    begin
      state_reg        <= state_next;
      pos_reg          <= pos_next;
      limit_reg        <= limit_next;
      send_after_reg   <= send_after_next;
      step_reg         <= step_next;
      pointer_reg      <= pointer_next;
      rotate_reg       <= rotate_next;
      pointer_load_reg <= pointer_load_next;
      rotate_load_reg  <= rotate_load_next;
      halt_reg         <= halt_next;
      done_reg         <= done_next;
      src_ready_reg    <= src_ready_next;
    end
  end

  // ==========================================================================
  // Staging buffer storage, one flip-flop group per character position
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < xfer_pkg::BUF_CHARS; g++)
    begin : g_stage
      logic [CHAR_W-1:0] cell_next;
      always_comb
      begin
        cell_next = stage_reg[g];
        if (stage_we && stage_waddr == POS_W'(g))
          cell_next = src_char_i;
      end
      always_ff @(posedge clk_sys_i or posedge reset_i)
      begin
        if (reset_i)
          stage_reg[g] <= '0;
        else if (enable_i)
          stage_reg[g] <= cell_next;
      end
    end
  endgenerate

  // ==========================================================================
  // Output buffer toward the destination; register stage keeps outputs flopped
  // ==========================================================================
  pair_buffer #(
    .WIDTH (CHAR_W)
  ) u_out_buf (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .enable_i    (enable_i),
    .in_valid_i  (buf_in_valid),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (buf_in_data),
    .out_valid_o (buf_out_valid),
    .out_ready_i (dst_ready_i),
    .out_data_o  (buf_out_data)
  );

  assign src_ready_o           = src_ready_reg;
  assign dst_valid_o           = buf_out_valid;
  assign dst_char_o            = buf_out_data;
  assign bulk_store_pointer_o  = pointer_reg;
  assign pointer_load_o        = pointer_load_reg;
  assign rotate_holding_word_o = rotate_reg;
  assign rotate_load_o         = rotate_load_reg;
  assign halt_o                = halt_reg;
  assign done_o                = done_reg;
  assign step_code_o           = step_reg;

endmodule // buffer_transfer_load_clear_unit

// ---- buffer_transfer_load_clear_unit_asserts.sv ----
`timescale 1ns/1ps
// ======================================================================
// Port-level checker for the transfer, load and clear unit
module buffer_transfer_load_clear_unit_asserts #(
  parameter int CHAR_W = xfer_pkg::CHAR_W
) (
  input wire logic              clk_sys_i,
  input wire logic              reset_i,
  input wire logic              start_i,
  input wire logic [11:0]       op_code_i,
  input wire logic [17:0]       u_section_i,
  input wire logic [17:0]       v_section_i,
  input wire logic [17:0]       w_section_i,
  input wire logic [5:0]        step_code_i,
  input wire logic [2:0]        src_class_i,
  input wire logic [2:0]        dst_class_i,
  input wire logic              src_ready_o,
  input wire logic              dst_valid_o,
  input wire logic [CHAR_W-1:0] dst_char_o,
  input wire logic [41:0]       bulk_store_pointer_o,
  input wire logic              pointer_load_o,
  input wire logic [71:0]       rotate_holding_word_o,
  input wire logic              rotate_load_o,
  input wire logic              halt_o,
  input wire logic              done_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  // Accepted copy request; the bench never starts while busy
  logic cp_go;
  logic clr_mode_reg;
  assign cp_go = start_i && op_code_i == xfer_pkg::OP_BUFFER_COPY && !halt_o;

  // Marks a clear in flight so its output characters can be judged
  always_ff @(posedge clk_sys_i or posedge reset_i)
    if (reset_i)
      clr_mode_reg <= 1'b0;
    else if (start_i && op_code_i == xfer_pkg::OP_CLEAR_TRACK)
      clr_mode_reg <= 1'b1;
    else if (done_o)
      clr_mode_reg <= 1'b0;

  // ======================================================================
  // Load instructions
  ptr_done_a: assert property (pointer_load_o |=> done_o)
    else $error("pointer load not followed by end pulse");
  ptr_value_a: assert property (pointer_load_o |-> $past(start_i) &&
    bulk_store_pointer_o == {$past(u_section_i[11:0]), $past(v_section_i),
    $past(w_section_i[17:6])})
    else $error("pointer digits misplaced");
  rot_value_a: assert property (rotate_load_o |->
    rotate_holding_word_o == {$past(u_section_i), $past(v_section_i), $past(w_section_i),
    $past(op_code_i), $past(step_code_i)})
    else $error("rotate holding word wrong");
  rot_timing_a: assert property (start_i && op_code_i == xfer_pkg::OP_LOAD_ROTATE &&
    !halt_o |=> rotate_load_o ##1 done_o)
    else $error("rotate load timing wrong");

  // ======================================================================
  // Copy halves and faults
  both_stage_a: assert property (cp_go && src_class_i == xfer_pkg::LOC_STAGING &&
    dst_class_i == xfer_pkg::LOC_STAGING |=> !src_ready_o && !dst_valid_o ##1 done_o)
    else $error("staging to staging not immediate");
  stage_src_a: assert property (cp_go && src_class_i == xfer_pkg::LOC_STAGING &&
    dst_class_i != xfer_pkg::LOC_STAGING |=> !src_ready_o [*4])
    else $error("source accepted for staging source");
  stage_dst_a: assert property (cp_go && dst_class_i == xfer_pkg::LOC_STAGING &&
    src_class_i != xfer_pkg::LOC_STAGING |=> !dst_valid_o [*8])
    else $error("output sent for staging destination");
  bad_src_a: assert property (cp_go && src_class_i == xfer_pkg::LOC_DRUM_PAT |=> halt_o)
    else $error("forbidden source did not halt");
  halt_hold_a: assert property (halt_o |=> halt_o && !done_o)
    else $error("halt released or end pulse while halted");
  done_quiet_a: assert property (done_o |-> !dst_valid_o)
    else $error("output still pending at end pulse");
  clear_space_a: assert property (dst_valid_o && clr_mode_reg |->
    dst_char_o == xfer_pkg::SPACE_CODE)
    else $error("clear sent a non-space character");
endmodule // buffer_transfer_load_clear_unit_asserts

bind buffer_transfer_load_clear_unit buffer_transfer_load_clear_unit_asserts #(
  .CHAR_W(CHAR_W)
) chk (
  .clk_sys_i, .reset_i, .start_i, .op_code_i, .u_section_i, .v_section_i, .w_section_i,
  .step_code_i, .src_class_i, .dst_class_i, .src_ready_o, .dst_valid_o, .dst_char_o,
  .bulk_store_pointer_o, .pointer_load_o, .rotate_holding_word_o, .rotate_load_o,
  .halt_o, .done_o
);

// ---- buffer_transfer_load_clear_unit_test.sv ----
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("CHECK FAILED at %0t got %h exp %h", $time, (got), (exp)); \
    end \
  end

// ======================================================================
// Self-checking bench, stimulus on the falling edge
module buffer_transfer_load_clear_unit_test;
  logic        clk_sys_i;
  logic        reset_i;
  logic        enable_i;
  logic        start_i;
  logic [11:0] op_code_i;
  logic [17:0] u_section_i;
  logic [17:0] v_section_i;
  logic [17:0] w_section_i;
  logic [5:0]  step_code_i;
  logic [2:0]  src_class_i;
  logic [6:0]  src_len_i;
  logic [2:0]  dst_class_i;
  logic [6:0]  dst_len_i;
  logic        src_valid_i;
  logic        src_ready_o;
  logic [5:0]  src_char_i;
  logic        dst_valid_o;
  logic        dst_ready_i;
  logic [5:0]  dst_char_o;
  logic [41:0] bulk_store_pointer_o;
  logic        pointer_load_o;
  logic [71:0] rotate_holding_word_o;
  logic        rotate_load_o;
  logic        halt_o;
  logic        done_o;
  logic [5:0]  step_code_o;
  logic [41:0] ptr_exp;
  logic [71:0] rot_exp;
  logic [5:0]  sb [0:119];
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  buffer_transfer_load_clear_unit uut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .enable_i(enable_i), .start_i(start_i),
    .op_code_i(op_code_i), .u_section_i(u_section_i), .v_section_i(v_section_i),
    .w_section_i(w_section_i), .step_code_i(step_code_i), .src_class_i(src_class_i),
    .src_len_i(src_len_i), .dst_class_i(dst_class_i), .dst_len_i(dst_len_i),
    .src_valid_i(src_valid_i), .src_ready_o(src_ready_o), .src_char_i(src_char_i),
    .dst_valid_o(dst_valid_o), .dst_ready_i(dst_ready_i), .dst_char_o(dst_char_o),
    .bulk_store_pointer_o(bulk_store_pointer_o), .pointer_load_o(pointer_load_o),
    .rotate_holding_word_o(rotate_holding_word_o), .rotate_load_o(rotate_load_o),
    .halt_o(halt_o), .done_o(done_o), .step_code_o(step_code_o)
  );

  // Free-running 100 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard: a stuck handshake ends the run as a failure
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ======================================================================
  // Shared drivers; ready stays low at issue so no output slips by unseen
  task automatic issue(input logic [11:0] op, input logic [2:0] sc, input logic [6:0] sl,
                       input logic [2:0] dc, input logic [6:0] dl);
    @(negedge clk_sys_i);
    op_code_i = op;
    src_class_i = sc;
    src_len_i = sl;
    dst_class_i = dc;
    dst_len_i = dl;
    dst_ready_i = 1'b0;
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
  endtask

  // Ready is a register, so its falling-edge value is what the next edge sees
  task automatic feed(input int n, input logic [5:0] base);
    int i;
    int k;
    logic rdy;
    i = 0;
    k = 0;
    while (i < n && k < 1000)
    begin
      src_valid_i = 1'b1;
      src_char_i = base + 6'(i);
      rdy = src_ready_o;
      @(posedge clk_sys_i);
      if (rdy === 1'b1)
      begin
        sb[i] = base + 6'(i);
        i++;
      end
      @(negedge clk_sys_i);
      k++;
    end
    src_valid_i = 1'b0;
    `CHECK(i, n)
  endtask

  // Receiver stalls four cycles in eight, enough to fill the pair buffer
  task automatic collect(input int n, input logic clr);
    int j;
    int k;
    logic [5:0] exp;
    j = 0;
    k = 0;
    while (j < n && k < 1000)
    begin
      @(negedge clk_sys_i);
      dst_ready_i = (k % 8) > 3;
      exp = clr ? xfer_pkg::SPACE_CODE : sb[j];
      if (dst_valid_o === 1'b1 && dst_ready_i)
      begin
        `CHECK(dst_char_o, exp)
        j++;
      end
      k++;
    end
    `CHECK(j, n)
  endtask

  task automatic wait_done();
    int k;
    k = 0;
    while (done_o !== 1'b1 && k < 300)
    begin
      @(negedge clk_sys_i);
      k++;
    end
    `CHECK(done_o, 1'b1)
  endtask

  task automatic run_copy(input logic [2:0] sc, input logic [6:0] sl, input logic [2:0] dc,
                          input logic [6:0] dl, input logic [5:0] base);
    issue(xfer_pkg::OP_BUFFER_COPY, sc, sl, dc, dl);
    if (sc != xfer_pkg::LOC_STAGING)
      feed(int'(sl), base);
    if (dc != xfer_pkg::LOC_STAGING)
      collect(int'(dl), 1'b0);
    wait_done();
  endtask

  // ======================================================================
  // Scenarios
  task automatic t_load_pointer();
    u_section_i = 18'h2_A5C3;
    v_section_i = 18'h1_B7E4;
    w_section_i = 18'h3_C2D9;
    step_code_i = 6'h2A;
    ptr_exp = {u_section_i[11:0], v_section_i, w_section_i[17:6]};
    issue(xfer_pkg::OP_LOAD_POINTER, xfer_pkg::LOC_INVALID, xfer_pkg::LEN_ZERO,
          xfer_pkg::LOC_INVALID, xfer_pkg::LEN_ZERO);
    wait_done();
    `CHECK(bulk_store_pointer_o, ptr_exp)
    `CHECK(step_code_o, 6'h2A)
  endtask

  task automatic t_load_rotate();
    u_section_i = 18'h0_4C1E;
    v_section_i = 18'h2_9037;
    w_section_i = 18'h1_65AB;
    step_code_i = 6'h13;
    issue(xfer_pkg::OP_LOAD_ROTATE, xfer_pkg::LOC_INVALID, xfer_pkg::LEN_ZERO,
          xfer_pkg::LOC_INVALID, xfer_pkg::LEN_ZERO);
    wait_done();
    rot_exp = {18'h0_4C1E, 18'h2_9037, 18'h1_65AB, xfer_pkg::OP_LOAD_ROTATE, 6'h13};
    `CHECK(rotate_holding_word_o, rot_exp)
    `CHECK(bulk_store_pointer_o, ptr_exp)
  endtask

  // Drum word into a longer field: upper part shows older staging content
  task automatic t_copy_grow();
    run_copy(xfer_pkg::LOC_DRUM_WORD, xfer_pkg::LEN_WORD, xfer_pkg::LOC_STORE_FLD,
             7'h14, 6'h01);
  endtask

  task automatic t_copy_shrink();
    run_copy(xfer_pkg::LOC_STORE_FLD, 7'h1E, xfer_pkg::LOC_DRUM_WORD,
             xfer_pkg::LEN_WORD, 6'h20);
  endtask

  task automatic t_copy_full();
    run_copy(xfer_pkg::LOC_STORE_FLD, xfer_pkg::LEN_FULL, xfer_pkg::LOC_PATTERN,
             xfer_pkg::LEN_FULL, 6'h05);
    run_copy(xfer_pkg::LOC_STAGING, xfer_pkg::LEN_FULL, xfer_pkg::LOC_DRUM_PAT,
             xfer_pkg::LEN_FULL, 6'h00);
  endtask

  // Load only, then send from the staging buffer in a second copy
  task automatic t_stage_ends();
    run_copy(xfer_pkg::LOC_STORE_FLD, xfer_pkg::LEN_FIELD_MAX, xfer_pkg::LOC_STAGING,
             xfer_pkg::LEN_FIELD_MAX, 6'h11);
    run_copy(xfer_pkg::LOC_STAGING, 7'h19, xfer_pkg::LOC_STORE_FLD, 7'h19, 6'h00);
    run_copy(xfer_pkg::LOC_STAGING, xfer_pkg::LEN_FULL, xfer_pkg::LOC_STAGING,
             xfer_pkg::LEN_FULL, 6'h00);
  endtask

  task automatic t_clear();
    step_code_i = 6'h15;
    issue(xfer_pkg::OP_CLEAR_TRACK, xfer_pkg::LOC_INVALID, xfer_pkg::LEN_ZERO,
          xfer_pkg::LOC_STORE_FLD, xfer_pkg::LEN_FULL);
    collect(120, 1'b1);
    wait_done();
    `CHECK(step_code_o, 6'h15)
  endtask

  // Forbidden source halts; a later load is then refused
  task automatic t_bad_source();
    issue(xfer_pkg::OP_BUFFER_COPY, xfer_pkg::LOC_DRUM_PAT, xfer_pkg::LEN_FULL,
          xfer_pkg::LOC_STORE_FLD, 7'h0A);
    @(negedge clk_sys_i);
    `CHECK(halt_o, 1'b1)
    u_section_i = 18'h3_FFFF;
    issue(xfer_pkg::OP_LOAD_POINTER, xfer_pkg::LOC_INVALID, xfer_pkg::LEN_ZERO,
          xfer_pkg::LOC_INVALID, xfer_pkg::LEN_ZERO);
    repeat (4) @(negedge clk_sys_i);
    `CHECK(bulk_store_pointer_o, ptr_exp)
  endtask

  // Main sequence
  initial
  begin
    {start_i, op_code_i, u_section_i, v_section_i, w_section_i, step_code_i} = '0;
    {src_class_i, src_len_i, dst_class_i, dst_len_i, src_valid_i, src_char_i} = '0;
    dst_ready_i = 1'b0;
    enable_i = 1'b1;
    reset_i = 1'b1;
    ptr_exp = '0;
    for (int i = 0; i < 120; i++)
      sb[i] = 6'h00;
    repeat (10) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    reset_i = 1'b0;
    t_load_pointer();
    t_load_rotate();
    t_copy_grow();
    t_copy_shrink();
    t_copy_full();
    t_stage_ends();
    t_clear();
    t_bad_source();
    final_report();
  end
endmodule // buffer_transfer_load_clear_unit_test
